// ### pqco_engine.sv
// Power query and configuration overlay command engine
// Contract
// R1: Power query accepted on both opcodes.
// R2: Count gets all ones only when spun up.
// R3: One overlay opcode, feature selects operation.
// R4: Features C0 to C3 decoded, others reserved.
// R5: Restore undoes every earlier reduction.
// R6: After freeze, all overlay operations abort.
// R7: Freeze survives hardware and software resets.
// R8: Overlay identify sends 512 bytes by PIO.
// R9: Normal identify shows reduced, overlay identify full.
// R10: Set may clear bits in five words only.
// R11: Cleared bit withdraws that capability.
// R12: Bit set beyond identify data ignored.
// R13: Restriction breach aborts instead of applying.
// R14: Abort reports reason, word and bit.
// R15: Reason codes 01,02,03,04,06,FF.
// R16: Signature A5, whole byte sum zero.
// R17: Any abort sets abort and error bits.
// R18: Freeze flag only cleared at power-on.
`timescale 1ns/1ps
`default_nettype none
module pqco_engine (
  // Clock, power-on reset and drive reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        driveReset,
  // Command block writes
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [7:0]  featureIn,
  // Drive state
  input  wire logic        spindleAtSpeed,
  input  wire logic        standbyOrSleep,
  input  wire logic        securityLocked,
  input  wire logic        protectedArea,
  // PIO data-in (device to host)
  output logic [15:0]      dataOut,
  output logic             dataOutValid,
  input  wire logic        dataOutTake,
  // PIO data-out (host to device)
  input  wire logic [15:0] dataIn,
  input  wire logic        dataInValid,
  // Result registers
  output logic [7:0]       statusOut,
  output logic [7:0]       errorOut,
  output logic [7:0]       sectorCount,
  output logic [7:0]       cylLow,
  output logic [7:0]       cylHigh,
  output logic             cmdDone,
  // Effective capability words for normal identify
  output logic [79:0]      capEffective
);
  typedef enum logic [1:0] {PQ_IDLE, PQ_SEND, PQ_RECV} pqco_state_t;

  pqco_state_t state_reg, state_next;
  logic [7:0]  idx_reg, idx_next;
  logic [7:0]  status_reg, status_next;
  logic [7:0]  error_reg, error_next;
  logic [7:0]  count_reg, count_next;
  logic [7:0]  cylLow_reg, cylLow_next;
  logic [7:0]  cylHigh_reg, cylHigh_next;
  logic        done_reg, done_next;
  logic        frozen_reg, frozen_next;
  logic        modified_reg, modified_next;
  logic        bad_reg, bad_next;
  logic [7:0]  badRsn_reg, badRsn_next;
  logic [7:0]  badWord_reg, badWord_next;
  logic [7:0]  badBit_reg, badBit_next;
  logic [15:0] dOut_reg, dOut_next;
  logic        dValid_reg, dValid_next;
  logic [15:0] cap_reg [pqco_pkg::NCAP];
  logic [15:0] cap_next [pqco_pkg::NCAP];
  logic [15:0] stage_reg [pqco_pkg::NCAP];
  logic [15:0] stage_next [pqco_pkg::NCAP];
  logic [2:0]  romIdx;
  logic [15:0] romWord;
  logic        sumZero;
  logic        sumClear;
  logic        sumValid;
  logic [15:0] sumWord;
  logic        isQuery;
  logic        isOverlay;

  // Full capability table
  pqco_ident_rom u_rom (
    .capIdx  (romIdx),
    .capWord (romWord)
  );

  // Byte sum of the structure
  pqco_checksum u_sum (
    .mclk      (mclk),
    .rstn      (rstn),
    .clear     (sumClear),
    .wordValid (sumValid),
    .wordIn    (sumWord),
    .sumZero   (sumZero)
  );

  assign isQuery   = (cmdCode == pqco_pkg::OP_POWER_QUERY) ||
                     (cmdCode == pqco_pkg::OP_POWER_QUERY_ALT); // see R1
  assign isOverlay = (cmdCode == pqco_pkg::OP_OVERLAY); // see R3
  assign sumClear  = (state_reg == PQ_IDLE);
  assign sumValid  = (state_reg == PQ_RECV) ? dataInValid : dValid_reg && dataOutTake;
  assign sumWord   = dValid_reg ? dOut_reg : dataIn;

  // Capability slot of a structure word index, 7 when none
  function automatic logic [2:0] capSlot(input logic [7:0] w);
    unique case (w)
      pqco_pkg::CAP_W0: capSlot = 3'h0;
      pqco_pkg::CAP_W1: capSlot = 3'h1;
      pqco_pkg::CAP_W2: capSlot = 3'h2;
      pqco_pkg::CAP_W3: capSlot = 3'h3;
      pqco_pkg::CAP_W4: capSlot = 3'h4;
      default:          capSlot = 3'h7;
    endcase
  endfunction

  // Lowest set bit index of a mask
  function automatic logic [7:0] lowBit(input logic [15:0] m);
    lowBit = 8'h00;
    for (int b = 15; b >= 0; b--)
      if (m[b])
        lowBit = 8'(b);
  endfunction

  assign romIdx = capSlot(idx_reg);

  // Command sequencing and result registers
  always_comb
  begin
    state_next    = state_reg;
    idx_next      = idx_reg;
    status_next   = status_reg;
    error_next    = error_reg;
    count_next    = count_reg;
    cylLow_next   = cylLow_reg;
    cylHigh_next  = cylHigh_reg;
    done_next     = 1'b0;
    frozen_next   = frozen_reg;
    modified_next = modified_reg;
    bad_next      = bad_reg;
    badRsn_next   = badRsn_reg;
    badWord_next  = badWord_reg;
    badBit_next   = badBit_reg;
    dOut_next     = dOut_reg;
    dValid_next   = dValid_reg;
    for (int i = 0; i < pqco_pkg::NCAP; i++)
    begin
      cap_next[i]   = cap_reg[i];
      stage_next[i] = stage_reg[i];
    end
    unique case (state_reg)
      PQ_IDLE:
        if (cmdWrite && isQuery)
        begin
          status_next = pqco_pkg::STATUS_RST;
          error_next  = pqco_pkg::ZERO8;
          count_next  = (spindleAtSpeed && !standbyOrSleep) ?
                        pqco_pkg::PWR_ACTIVE : pqco_pkg::PWR_IDLE; // see R2
          done_next   = 1'b1;
        end
        else if (cmdWrite && isOverlay)
        begin
          status_next  = pqco_pkg::STATUS_RST;
          error_next   = pqco_pkg::ZERO8;
          cylLow_next  = pqco_pkg::ZERO8;
          cylHigh_next = pqco_pkg::ZERO8;
          idx_next     = pqco_pkg::ZERO8;
          if (frozen_reg || !(featureIn inside {pqco_pkg::FT_RESTORE, pqco_pkg::FT_FREEZE,
                                                pqco_pkg::FT_IDENT, pqco_pkg::FT_SET}))
          begin
            // Frozen or reserved feature aborts at once
            status_next[pqco_pkg::ST_ERR] = 1'b1; // see R6, R17
            error_next[pqco_pkg::ER_ABT]  = 1'b1; // see R17
            count_next = frozen_reg ? pqco_pkg::RSN_FROZEN : pqco_pkg::RSN_OTHER; // see R15
            done_next  = 1'b1;
          end
          else
          begin
            unique case (featureIn) // see R4
              pqco_pkg::FT_RESTORE:
              begin
                if (protectedArea)
                begin
                  status_next[pqco_pkg::ST_ERR] = 1'b1; // see R17
                  error_next[pqco_pkg::ER_ABT]  = 1'b1;
                  count_next = pqco_pkg::RSN_PROTECT;
                end
                else
                begin
                  for (int i = 0; i < pqco_pkg::NCAP; i++)
                    cap_next[i] = 16'hffff; // see R5
                  modified_next = 1'b0;
                end
                done_next = 1'b1;
              end
              pqco_pkg::FT_FREEZE:
              begin
                frozen_next = 1'b1; // see R6
                done_next   = 1'b1;
              end
              pqco_pkg::FT_IDENT:
              begin
                state_next = PQ_SEND; // see R8
                status_next[pqco_pkg::ST_DRQ] = 1'b1;
              end
              default:
              begin
                state_next = PQ_RECV; // see R10
                bad_next   = 1'b0;
                status_next[pqco_pkg::ST_DRQ] = 1'b1;
              end
            endcase
          end
        end
      PQ_SEND:
        if (!dValid_reg || dataOutTake)
        begin
          if (dValid_reg && idx_reg == pqco_pkg::ZERO8)
          begin
            dValid_next = 1'b0;
            state_next  = PQ_IDLE;
            status_next[pqco_pkg::ST_DRQ] = 1'b0;
            done_next   = 1'b1;
          end
          else
          begin
            // Full set, not the reduced one; see R9
            if (idx_reg == pqco_pkg::ZERO8)
              dOut_next = 16'h0001;
            else if (romIdx != 3'h7)
              dOut_next = romWord;
            else
              dOut_next = 16'h0000;
            // Checksum closes the structure; see R16
            if (idx_reg == pqco_pkg::LAST_WORD)
              dOut_next = {8'(8'h00 - sumAfter(dOut_reg) - pqco_pkg::SIGNATURE), pqco_pkg::SIGNATURE};
            dValid_next = 1'b1;
            idx_next    = 8'(idx_reg + 8'h01);
          end
        end
      PQ_RECV:
        if (dataInValid)
        begin
          if (romIdx != 3'h7)
          begin
            // Bits beyond the full set are ignored; see R12
            stage_next[romIdx] = dataIn & romWord;
            if (!bad_reg && ((~dataIn & romWord & ~cap_reg[romIdx]) != 16'h0000))
            begin
              bad_next = 1'b1; // see R13
            end
          end
          if (idx_reg == pqco_pkg::LAST_WORD)
          begin
            state_next = PQ_IDLE;
            status_next[pqco_pkg::ST_DRQ] = 1'b0;
            done_next  = 1'b1;
            if (securityLocked || modified_reg || protectedArea || bad_reg ||
                dataIn[7:0] != pqco_pkg::SIGNATURE ||
                8'(sumAfter(dataIn)) != pqco_pkg::ZERO8) // see R16
            begin
              status_next[pqco_pkg::ST_ERR] = 1'b1; // see R13, R17
              error_next[pqco_pkg::ER_ABT]  = 1'b1;
              count_next   = securityLocked ? pqco_pkg::RSN_SECURITY :
                             modified_reg   ? pqco_pkg::RSN_MODIFIED :
                             protectedArea  ? pqco_pkg::RSN_PROTECT  :
                             bad_reg        ? badRsn_reg : pqco_pkg::RSN_OTHER; // see R14, R15
              cylHigh_next = bad_reg ? badWord_reg : pqco_pkg::ZERO8;
              cylLow_next  = bad_reg ? badBit_reg : pqco_pkg::ZERO8;
            end
            else
            begin
              for (int i = 0; i < pqco_pkg::NCAP; i++)
                cap_next[i] = stage_reg[i]; // see R11
              modified_next = 1'b1;
            end
          end
          else
            idx_next = 8'(idx_reg + 8'h01);
        end
      default:
        state_next = PQ_IDLE;
    endcase
    // First offending bit recorded once
    if (state_reg == PQ_RECV && dataInValid && romIdx != 3'h7 && !bad_reg &&
        ((~dataIn & romWord & ~cap_reg[romIdx]) != 16'h0000))
    begin
      badRsn_next  = pqco_pkg::RSN_DISABLE; // see R14
      badWord_next = idx_reg;
      badBit_next  = lowBit(~dataIn & romWord & ~cap_reg[romIdx]);
    end
    // Drive reset leaves frozen and overlay alone; see R7
    if (driveReset)
    begin
      state_next  = PQ_IDLE;
      dValid_next = 1'b0;
      status_next = pqco_pkg::STATUS_RST;
    end
  end

  // Byte sum including the last word
  function automatic logic [7:0] sumAfter(input logic [15:0] w);
    sumAfter = 8'(u_sum.sum_reg + w[7:0] + w[15:8]);
  endfunction

  // Registers; only power-on clears freeze and overlay, see R18
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg    <= PQ_IDLE;
      idx_reg      <= 8'h00;
      status_reg   <= pqco_pkg::STATUS_RST;
      error_reg    <= pqco_pkg::ZERO8;
      count_reg    <= pqco_pkg::ZERO8;
      cylLow_reg   <= pqco_pkg::ZERO8;
      cylHigh_reg  <= pqco_pkg::ZERO8;
      done_reg     <= 1'b0;
      frozen_reg   <= 1'b0;
      modified_reg <= 1'b0;
      bad_reg      <= 1'b0;
      badRsn_reg   <= pqco_pkg::ZERO8;
      badWord_reg  <= pqco_pkg::ZERO8;
      badBit_reg   <= pqco_pkg::ZERO8;
      dOut_reg     <= 16'h0000;
      dValid_reg   <= 1'b0;
      for (int i = 0; i < pqco_pkg::NCAP; i++)
      begin
        cap_reg[i]   <= 16'hffff;
        stage_reg[i] <= 16'h0000;
      end
    end
    else
    begin
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      status_reg   <= status_next;
      error_reg    <= error_next;
      count_reg    <= count_next;
      cylLow_reg   <= cylLow_next;
      cylHigh_reg  <= cylHigh_next;
      done_reg     <= done_next;
      frozen_reg   <= frozen_next;
      modified_reg <= modified_next;
      bad_reg      <= bad_next;
      badRsn_reg   <= badRsn_next;
      badWord_reg  <= badWord_next;
      badBit_reg   <= badBit_next;
      dOut_reg     <= dOut_next;
      dValid_reg   <= dValid_next;
      for (int i = 0; i < pqco_pkg::NCAP; i++)
      begin
        cap_reg[i]   <= cap_next[i];
        stage_reg[i] <= stage_next[i];
      end
    end
  end

  // Outputs straight from flip-flops
  assign statusOut    = status_reg;
  assign errorOut     = error_reg;
  assign sectorCount  = count_reg;
  assign cylLow       = cylLow_reg;
  assign cylHigh      = cylHigh_reg;
  assign cmdDone      = done_reg;
  assign dataOut      = dOut_reg;
  assign dataOutValid = dValid_reg;
  assign capEffective = {cap_reg[4], cap_reg[3], cap_reg[2], cap_reg[1], cap_reg[0]};
endmodule
`default_nettype wire

// ### pqco_pkg.sv
// Package of opcodes, feature codes, reason codes and layout constants
package pqco_pkg;
  // Command opcodes
  localparam logic [7:0] OP_POWER_QUERY     = 8'he5;
  localparam logic [7:0] OP_POWER_QUERY_ALT = 8'h98;
  localparam logic [7:0] OP_OVERLAY         = 8'hb1;
  // Overlay feature values
  localparam logic [7:0] FT_RESTORE = 8'hc0;
  localparam logic [7:0] FT_FREEZE  = 8'hc1;
  localparam logic [7:0] FT_IDENT   = 8'hc2;
  localparam logic [7:0] FT_SET     = 8'hc3;
  // Power query answers
  localparam logic [7:0] PWR_ACTIVE = 8'hff;
  localparam logic [7:0] PWR_IDLE   = 8'h00;
  // Abort reason codes
  localparam logic [7:0] RSN_FROZEN   = 8'h01;
  localparam logic [7:0] RSN_SECURITY = 8'h02;
  localparam logic [7:0] RSN_MODIFIED = 8'h03;
  localparam logic [7:0] RSN_DISABLE  = 8'h04;
  localparam logic [7:0] RSN_PROTECT  = 8'h06;
  localparam logic [7:0] RSN_OTHER    = 8'hff;
  // Structure layout
  localparam int          WORDS      = 256;
  localparam logic [7:0]  LAST_WORD  = 8'hff;
  localparam logic [7:0]  SIGNATURE  = 8'ha5;
  localparam int          NCAP       = 5;
  // Capability word indexes in the normal identify response
  localparam logic [7:0]  CAP_W0 = 8'h3f; // 63
  localparam logic [7:0]  CAP_W1 = 8'h52; // 82
  localparam logic [7:0]  CAP_W2 = 8'h53; // 83
  localparam logic [7:0]  CAP_W3 = 8'h54; // 84
  localparam logic [7:0]  CAP_W4 = 8'h58; // 88
  // Status and error bit positions
  localparam int ST_ERR = 0;
  localparam int ST_DRQ = 3;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  localparam int ER_ABT = 2;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [7:0] ZERO8      = 8'h00;
endpackage

// ### pqco_checksum.sv
// Running byte-sum checker for the overlay structure
`timescale 1ns/1ps
`default_nettype none
module pqco_checksum (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Control
  input  wire logic        clear,
  input  wire logic        wordValid,
  input  wire logic [15:0] wordIn,
  // Result
  output logic             sumZero
);
  logic [7:0] sum_reg;
  logic [7:0] sum_next;

  // Accumulate both bytes, overflow dropped
  always_comb
  begin
    sum_next = sum_reg;
    if (clear)
      sum_next = pqco_pkg::ZERO8;
    else if (wordValid)
      sum_next = 8'(sum_reg + wordIn[7:0] + wordIn[15:8]);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sum_reg <= 8'h00;
    else
      sum_reg <= sum_next;
  end

  assign sumZero = (sum_reg == pqco_pkg::ZERO8);
endmodule
`default_nettype wire

// ### pqco_ident_rom.sv
// Selectable-capability table returned by overlay identify
`timescale 1ns/1ps
`default_nettype none
module pqco_ident_rom #(
  parameter logic [15:0] CAP63 = 16'h0007,
  parameter logic [15:0] CAP82 = 16'h7c6b,
  parameter logic [15:0] CAP83 = 16'h7f09,
  parameter logic [15:0] CAP84 = 16'h4003,
  parameter logic [15:0] CAP88 = 16'h003f
) (
  // Index in
  input  wire logic [2:0]  capIdx,
  // Full capability word out
  output logic      [15:0] capWord
);
  // Index to full selectable word
  always_comb
  begin
    unique case (capIdx)
      3'h0:    capWord = CAP63;
      3'h1:    capWord = CAP82;
      3'h2:    capWord = CAP83;
      3'h3:    capWord = CAP84;
      3'h4:    capWord = CAP88;
      default: capWord = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// ### pqco_engine_props.sv
// Assertions for the overlay command engine
`timescale 1ns/1ps
`default_nettype none
module pqco_engine_props (
  // Clock and resets
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        driveReset,
  // Command and drive state
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdCode,
  input wire logic [7:0]  featureIn,
  input wire logic        spindleAtSpeed,
  input wire logic        standbyOrSleep,
  // Results
  input wire logic [15:0] dataOut,
  input wire logic        dataOutValid,
  input wire logic        dataOutTake,
  input wire logic [7:0]  statusOut,
  input wire logic [7:0]  errorOut,
  input wire logic [7:0]  sectorCount,
  input wire logic        cmdDone,
  input wire logic [79:0] capEffective
);
  logic       frozen_reg;
  logic       frozen_next;
  logic [7:0] feat_reg;
  logic [7:0] feat_next;
  logic       take;
  logic       ovl;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Command accepted at this edge
  assign take = cmdWrite && !statusOut[pqco_pkg::ST_DRQ] && !driveReset;
  assign ovl  = take && cmdCode == pqco_pkg::OP_OVERLAY;
  // Last overlay feature and freeze flag, next values
  always_comb
  begin
    feat_next   = ovl ? featureIn : (take ? 8'h00 : feat_reg);
    frozen_next = frozen_reg || (cmdDone && feat_reg == pqco_pkg::FT_FREEZE && !statusOut[pqco_pkg::ST_ERR]);
  end
  // Only power-on clears the freeze tracker
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      feat_reg   <= 8'h00;
      frozen_reg <= 1'b0;
    end
    else
    begin
      feat_reg   <= feat_next;
      frozen_reg <= frozen_next;
    end
  end
  chk_query_answer: assert property (
    take && (cmdCode == pqco_pkg::OP_POWER_QUERY || cmdCode == pqco_pkg::OP_POWER_QUERY_ALT)
    |=> cmdDone && !statusOut[pqco_pkg::ST_ERR]
    && sectorCount == (($past(spindleAtSpeed) && !$past(standbyOrSleep)) ? 8'hff : 8'h00))
    else $error("power query answer wrong");
  chk_frozen_abort: assert property (
    ovl && frozen_reg |=> cmdDone && sectorCount == pqco_pkg::RSN_FROZEN && statusOut[pqco_pkg::ST_ERR])
    else $error("frozen overlay not aborted");
  chk_reserved_abort: assert property (
    ovl && !frozen_reg && featureIn[7:2] != 6'h30 |=> cmdDone && sectorCount == pqco_pkg::RSN_OTHER
    && errorOut[pqco_pkg::ER_ABT])
    else $error("reserved feature not aborted");
  chk_abort_bits: assert property (
    cmdDone && statusOut[pqco_pkg::ST_ERR] |-> errorOut[pqco_pkg::ER_ABT])
    else $error("abort bit missing");
  chk_ident_start: assert property (
    ovl && !frozen_reg && featureIn == pqco_pkg::FT_IDENT |=> statusOut[pqco_pkg::ST_DRQ] ##1 dataOutValid)
    else $error("identify transfer late");
  chk_word_hold: assert property (
    dataOutValid && !dataOutTake |=> dataOutValid && $stable(dataOut))
    else $error("identify word dropped");
  chk_restore_full: assert property (
    cmdDone && feat_reg == pqco_pkg::FT_RESTORE && !statusOut[pqco_pkg::ST_ERR] |-> &capEffective)
    else $error("restore left reductions");
  chk_set_reason: assert property (
    cmdDone && feat_reg == pqco_pkg::FT_SET && statusOut[pqco_pkg::ST_ERR]
    |-> sectorCount inside {8'h02, 8'h03, 8'h04, 8'h06, 8'hff})
    else $error("set abort reason unknown");
endmodule
bind pqco_engine pqco_engine_props u_pqco_engine_props (.mclk(mclk), .rstn(rstn), .driveReset(driveReset),
  .cmdWrite(cmdWrite), .cmdCode(cmdCode), .featureIn(featureIn), .spindleAtSpeed(spindleAtSpeed),
  .standbyOrSleep(standbyOrSleep), .dataOut(dataOut), .dataOutValid(dataOutValid), .dataOutTake(dataOutTake),
  .statusOut(statusOut), .errorOut(errorOut), .sectorCount(sectorCount), .cmdDone(cmdDone),
  .capEffective(capEffective));
`default_nettype wire

// ### pqco_host_model.sv
// Host controller model driving the command block
`timescale 1ns/1ps
`default_nettype none
module pqco_host_model (
  // Clock
  input wire logic        mclk,
  // Command block writes
  output var logic        cmdWrite,
  output var logic [7:0]  cmdCode,
  output var logic [7:0]  featureIn,
  // PIO transfers
  input wire logic [15:0] dataOut,
  input wire logic        dataOutValid,
  output var logic        dataOutTake,
  output var logic [15:0] dataIn,
  output var logic        dataInValid,
  // Completion
  input wire logic [7:0]  statusOut,
  input wire logic        cmdDone
);
  logic [15:0] identWords [256];
  int          waitFails = 0;
  // Idle levels at time zero
  initial
  begin
    cmdWrite    = 1'b0;
    cmdCode     = 8'h00;
    featureIn   = 8'h00;
    dataOutTake = 1'b0;
    dataIn      = 16'h0000;
    dataInValid = 1'b0;
  end
  // Flag chosen by index: done, word valid, data request
  function automatic logic flag(input int w);
    return w == 0 ? cmdDone : (w == 1 ? dataOutValid : statusOut[pqco_pkg::ST_DRQ]);
  endfunction
  // Bounded wait for a flag
  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (flag(w) !== 1'b1 && n < 600)
    begin
      @(posedge mclk);
      #2;
      n++;
    end
    if (n == 600)
      waitFails++;
  endtask
  // One-cycle command write with features alongside
  task automatic issue(input logic [7:0] code, input logic [7:0] feat);
    @(posedge mclk);
    #2;
    cmdCode   = code;
    featureIn = feat;
    cmdWrite  = 1'b1;
    @(posedge mclk);
    #2;
    cmdWrite  = 1'b0;
  endtask
  // Read 256 words, idling between takes
  task automatic read_ident(input int stall);
    for (int i = 0; i < 256; i++)
    begin
      wait_for(1);
      identWords[i] = dataOut;
      dataOutTake   = 1'b1;
      @(posedge mclk);
      #2;
      dataOutTake = 1'b0;
      if (i < 255)
        repeat (1 + (i % 2) * stall)
        begin
          @(posedge mclk);
          #2;
        end
    end
  endtask
  // Push the overlay; checksum off by sumFix
  task automatic write_set(input logic [7:0] sumFix);
    wait_for(2);
    for (int i = 0; i < 256; i++)
    begin
      dataIn      = i == 0 ? 16'h0001 : (i == 255 ? {8'h5a + sumFix, pqco_pkg::SIGNATURE} : 16'h0000);
      dataInValid = 1'b1;
      @(posedge mclk);
      #2;
    end
    dataInValid = 1'b0;
    dataIn      = ~dataIn;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the overlay command engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, rstn, driveReset, cmdWrite, dataOutValid, dataOutTake, dataInValid, cmdDone;
  logic        spindleAtSpeed, standbyOrSleep, securityLocked, protectedArea;
  logic [7:0]  cmdCode, featureIn, statusOut, errorOut, sectorCount, cylLow, cylHigh;
  logic [15:0] dataOut, dataIn;
  logic [79:0] capEffective;
  int          mismatches = 0;
  int          samplesChecked = 0;
  // Device under test and host
  pqco_engine u_pqco_engine (.mclk(mclk), .rstn(rstn), .driveReset(driveReset), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .featureIn(featureIn), .spindleAtSpeed(spindleAtSpeed), .standbyOrSleep(standbyOrSleep),
    .securityLocked(securityLocked), .protectedArea(protectedArea), .dataOut(dataOut),
    .dataOutValid(dataOutValid), .dataOutTake(dataOutTake), .dataIn(dataIn), .dataInValid(dataInValid),
    .statusOut(statusOut), .errorOut(errorOut), .sectorCount(sectorCount), .cylLow(cylLow), .cylHigh(cylHigh),
    .cmdDone(cmdDone), .capEffective(capEffective));
  pqco_host_model u_pqco_host_model (.mclk(mclk), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .featureIn(featureIn),
    .dataOut(dataOut), .dataOutValid(dataOutValid), .dataOutTake(dataOutTake), .dataIn(dataIn),
    .dataInValid(dataInValid), .statusOut(statusOut), .cmdDone(cmdDone));
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    samplesChecked++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask
  // Completion results
  task automatic expect_abort(input logic [7:0] reason);
    u_pqco_host_model.wait_for(0);
    check("reason", sectorCount, reason);
    check("errBit", statusOut[pqco_pkg::ST_ERR], 1'b1);
    check("abtBit", errorOut[pqco_pkg::ER_ABT], 1'b1);
  endtask
  task automatic expect_ok();
    u_pqco_host_model.wait_for(0);
    check("okErr", statusOut[pqco_pkg::ST_ERR], 1'b0);
  endtask
  // Query on both opcodes and every drive state
  task automatic test_query();
    for (int c = 0; c < 2; c++)
      for (int s = 0; s < 4; s++)
      begin
        spindleAtSpeed = s[0];
        standbyOrSleep = s[1];
        u_pqco_host_model.issue(c == 0 ? pqco_pkg::OP_POWER_QUERY : pqco_pkg::OP_POWER_QUERY_ALT, 8'h00);
        u_pqco_host_model.wait_for(0);
        check("queryCount", sectorCount, s == 1 ? pqco_pkg::PWR_ACTIVE : pqco_pkg::PWR_IDLE);
        check("queryStatus", statusOut, pqco_pkg::STATUS_RST);
      end
  endtask
  // Reserved feature values around the decoded range
  task automatic test_reserved();
    logic [7:0] feats [4] = '{8'h00, 8'hbf, 8'hc4, 8'hff};
    for (int i = 0; i < 4; i++)
    begin
      u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, feats[i]);
      expect_abort(pqco_pkg::RSN_OTHER);
    end
  endtask
  // Identify with a stalling host
  task automatic test_identify();
    logic [7:0] sum;
    u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_IDENT);
    u_pqco_host_model.read_ident(2);
    u_pqco_host_model.wait_for(0);
    sum = 8'h00;
    for (int i = 0; i < 256; i++)
      sum += u_pqco_host_model.identWords[i][7:0] + u_pqco_host_model.identWords[i][15:8];
    check("identRev", u_pqco_host_model.identWords[0], 16'h0001);
    check("identSig", u_pqco_host_model.identWords[255][7:0], pqco_pkg::SIGNATURE);
    check("identSum", sum, 8'h00);
    check("identEnd", dataOutValid, 1'b0);
  endtask
  // Set refusals, apply, repeat and restore
  task automatic set_once(input logic [7:0] sumFix);
    u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_SET);
    u_pqco_host_model.write_set(sumFix);
  endtask
  task automatic test_set();
    securityLocked = 1'b1;
    set_once(8'h00);
    expect_abort(pqco_pkg::RSN_SECURITY);
    securityLocked = 1'b0;
    set_once(8'h01);
    expect_abort(pqco_pkg::RSN_OTHER);
    set_once(8'h00);
    expect_ok();
    check("capCut", &capEffective, 1'b0);
    set_once(8'h00);
    expect_abort(pqco_pkg::RSN_MODIFIED);
    protectedArea = 1'b1;
    u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_RESTORE);
    expect_abort(pqco_pkg::RSN_PROTECT);
    protectedArea = 1'b0;
    u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_RESTORE);
    expect_ok();
    check("capFull", &capEffective, 1'b1);
  endtask
  // Freeze, drive reset, then every operation refused
  task automatic test_freeze();
    u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_FREEZE);
    expect_ok();
    @(posedge mclk);
    #2;
    driveReset = 1'b1;
    @(posedge mclk);
    #2;
    driveReset = 1'b0;
    for (int f = 0; f < 4; f++)
    begin
      u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_RESTORE + 8'(f));
      expect_abort(pqco_pkg::RSN_FROZEN);
    end
  endtask
  // Power cycle clears the freeze
  task automatic test_power_on();
    rstn = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
    rstn = 1'b1;
    check("rstStatus", statusOut, pqco_pkg::STATUS_RST);
    u_pqco_host_model.issue(pqco_pkg::OP_OVERLAY, pqco_pkg::FT_RESTORE);
    expect_ok();
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (u_pqco_host_model.waitFails != 0)
      mismatches++;
    if (mismatches == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Main sequence
  initial
  begin
    rstn           = 1'b0;
    driveReset     = 1'b0;
    spindleAtSpeed = 1'b0;
    standbyOrSleep = 1'b0;
    securityLocked = 1'b0;
    protectedArea  = 1'b0;
    repeat (10) @(posedge mclk);
    #2;
    rstn = 1'b1;
    test_query();
    test_reserved();
    test_identify();
    test_set();
    test_freeze();
    test_power_on();
    summarize();
  end
  // Watchdog
  initial
  begin
    #(25 * 20000);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
